// ==== rtl/can_phy_ctrl.sv ====
// Functional notes
// R1: Driver enabled only in normal mode; silent mode disables it, timeout moot.
// R2: Transmit timeout timer starts at each falling edge of transmit input.
// R3: No rising edge before transmit timeout expires: driver off, bus released.
// R4: Transmit input high again re-enables driver and clears the timeout.
// R5: During transmit timeout receive output follows bus; bus stays recessive.
// R6: Controller keeps bit rate at least eleven bits over minimum timeout.
// R7: With receive supervision, timer starts at each falling receive output edge.
// R8: Bus dominant past receive timeout forces receive output high.
// R9: Recessive bus resumes mirroring and clears receive timeout.
// R10: During receive timeout the bus lines stay recessive, never dominant.
// R11: Over-temperature turns driver off; driver returns when it clears.
// R12: Thermal shutdown keeps bus recessive and receive path working.
// R13: Either supply low gives protected state; single-supply floats bus and receive.
// R14: Dual supply: main bad floats bus, receive high; output bad floats receive.
// R15: Normal operation resumes a recovery delay after both supplies are good.
// R16: Fault output released whenever any timeout, thermal or undervoltage is active.
// R17: A floating transmit input reads high, keeping the driver recessive.
// R18: A floating silent-select input reads low, giving normal mode.
// R19: Controller picks normal or silent mode only through silent-select; the control register silent bit can also force silent mode.
// R20: Silent-select high: driver off, receiver on; low: both enabled.
// R21: Receive output low while bus dominant, high while recessive.
// R22: Transmit timeout lies between 1175 and 3700 microseconds.
// R23: Receive timeout lies between 1380 and 4200 microseconds.
// R24: Each timeout is a counter cleared on start edge and on recessive level.
// R25: Fault is the OR of the four conditions, dropping once all clear.
//
// Top of the transceiver protection and control logic.
// Assumes all inputs synchronous to clk_i; pin pulls resolved here from the float flags.
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module can_phy_ctrl
    import can_phy_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller side
    input wire logic txd_i,
    input wire logic txd_float_i,
    input wire logic silent_i,
    input wire logic silent_float_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    // Bus side: receiver comparator result, driver and bias controls
    input wire logic bus_dominant_i,
    output logic bus_drive_dominant_o,
    output logic bus_bias_o,
    // Supervisors
    input wire logic over_temp_i,
    input wire logic main_supply_good_i,
    input wire logic out_supply_good_i,
    // Open-drain fault pin: output low when enabled
    output logic fault_o,
    output logic fault_oe_o,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);
    localparam logic [TIMER_W-1:0] TX_LIMIT = TIMER_W'(TX_TIMEOUT_CYCLES);
    localparam logic [TIMER_W-1:0] RX_LIMIT = TIMER_W'(RX_TIMEOUT_CYCLES);
    localparam logic [TIMER_W-1:0] REC_LIMIT = TIMER_W'(RECOVERY_CYCLES);

    logic [2:0] control;
    logic [STAT_W-1:0] status;
    logic txd_eff;
    logic silent_eff;
    logic rx_supervise;
    logic dual_supply;
    logic tx_timeout;
    logic rx_timeout;
    logic rxd_raw;
    logic rxd_mirror;
    logic supplies_good;
    logic protected_state;
    logic driver_on;
    logic any_fault;
    supply_state_t supply_state;
    supply_state_t next_supply_state;
    logic [TIMER_W-1:0] rec_count;
    logic [TIMER_W-1:0] next_rec_count;
    logic next_rxd;
    logic next_rxd_oe;
    logic next_drive;
    logic next_bias;
    logic next_fault_oe;

    // Floating pins fall back to their pull levels
    assign txd_eff = txd_float_i ? 1'b1 : txd_i; // R17
    assign silent_eff = silent_float_i ? 1'b0 : silent_i; // R18 R19
    assign rx_supervise = control[CTRL_RX_SUPERVISE_BIT];
    assign dual_supply = control[CTRL_DUAL_SUPPLY_BIT];
    // Software may force silent too; the pin still selects the mode alone if left at zero
    wire logic silent_mode = silent_eff | control[CTRL_SILENT_BIT];

    // Receiver comparator: dominant bus reads low
    assign rxd_raw = ~bus_dominant_i; // R21

    // Transmit supervision only matters while the driver could be active
    dominant_timeout #(
        .LIMIT(TX_LIMIT) // R22
    ) tx_supervisor (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(!silent_mode), // R1
        .line_i(txd_eff), // R2 R3 R4
        .expired_o(tx_timeout)
    );

    // Receive supervision watches the raw receiver, not the forced output
    dominant_timeout #(
        .LIMIT(RX_LIMIT) // R23
    ) rx_supervisor (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(rx_supervise),
        .line_i(rxd_raw), // R7 R9
        .expired_o(rx_timeout)
    );

    assign supplies_good = main_supply_good_i && (out_supply_good_i || !dual_supply);
    assign protected_state = supply_state != SUPPLY_NORMAL;

    // Protected until supplies stay good for the recovery delay
    always_comb begin
        next_supply_state = supply_state;
        next_rec_count = rec_count;
        case (supply_state)
            SUPPLY_NORMAL: begin
                if (!supplies_good) begin
                    next_supply_state = SUPPLY_PROTECTED; // R13
                end
            end
            SUPPLY_PROTECTED: begin
                next_rec_count = '0;
                if (supplies_good) begin
                    next_supply_state = SUPPLY_RECOVERING;
                end
            end
            SUPPLY_RECOVERING: begin
                if (!supplies_good) begin
                    next_supply_state = SUPPLY_PROTECTED;
                end else if (rec_count == REC_LIMIT - 16'h0001) begin
                    next_supply_state = SUPPLY_NORMAL; // R15
                end else begin
                    next_rec_count = rec_count + 16'h0001;
                end
            end
            default: next_supply_state = SUPPLY_PROTECTED;
        endcase
    end

    // Starts protected so the bus is never driven before supplies settle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            supply_state <= SUPPLY_PROTECTED;
            rec_count <= '0;
        end else begin
            supply_state <= next_supply_state;
            rec_count <= next_rec_count;
        end
    end

    // Driver permission: every protection blocks the dominant drive
    assign driver_on = !silent_mode && !tx_timeout && !rx_timeout // R1 R20 R3 R10
        && !over_temp_i && !protected_state; // R11 R12
    assign rxd_mirror = rx_timeout ? 1'b1 : rxd_raw; // R8 R5
    assign any_fault = tx_timeout || rx_timeout || over_temp_i || protected_state; // R16 R25

    // Pin outputs registered; one cycle of latency is far below bit times
    always_comb begin
        next_drive = driver_on && !txd_eff; // R4 R17
        next_bias = 1'b1; // R5 R10 R12
        next_rxd = rxd_mirror;
        next_rxd_oe = 1'b1;
        next_fault_oe = !any_fault; // R16 R25
        if (protected_state) begin
            next_drive = 1'b0;
            if (!main_supply_good_i) begin
                next_bias = 1'b0; // R13 R14
                next_rxd = 1'b1;
                next_rxd_oe = dual_supply && out_supply_good_i; // R14
            end else begin
                next_bias = 1'b1; // R14
                next_rxd_oe = !(dual_supply && !out_supply_good_i);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_drive_dominant_o <= 1'b0;
            bus_bias_o <= 1'b0;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
            fault_oe_o <= 1'b0;
        end else begin
            bus_drive_dominant_o <= next_drive;
            bus_bias_o <= next_bias;
            rxd_o <= next_rxd;
            rxd_oe_o <= next_rxd_oe;
            fault_oe_o <= next_fault_oe;
        end
    end

    // Open-drain data is always low; only the enable moves
    always_ff @(posedge clk_i) begin
        fault_o <= 1'b0;
    end

    assign status = {any_fault, driver_on, protected_state, over_temp_i, rx_timeout, tx_timeout};

    wb_regs bus_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .status_i(status),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .control_o(control)
    );
endmodule

// ==== include/can_phy_pkg.sv ====
// Package for the CAN transceiver protection and control logic.
// Assumes a 10 MHz local timebase clock driving all counters.
package can_phy_pkg;
    // Local timebase
    localparam int CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;

    // Transmit dominant-timeout window, microseconds
    localparam int TX_TIMEOUT_MIN_US = 1175;
    localparam int TX_TIMEOUT_MAX_US = 3700;
    // Receive dominant-timeout window, microseconds
    localparam int RX_TIMEOUT_MIN_US = 1380;
    localparam int RX_TIMEOUT_MAX_US = 4200;
    // Supply recovery delay, microseconds
    localparam int RECOVERY_US = 300;

    // Least time rounds up; the terminal count sits at the window minimum
    localparam int TX_TIMEOUT_CYCLES = (TX_TIMEOUT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_TIMEOUT_CYCLES = (RX_TIMEOUT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYCLES = (RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Counter width wide enough for every count above
    localparam int TIMER_W = 16;

    // Bus register offsets (word-aligned byte addresses)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // Control register fields
    localparam int CTRL_SILENT_BIT = 0;
    localparam int CTRL_RX_SUPERVISE_BIT = 1;
    localparam int CTRL_DUAL_SUPPLY_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status register fields
    localparam int STAT_TX_TIMEOUT_BIT = 0;
    localparam int STAT_RX_TIMEOUT_BIT = 1;
    localparam int STAT_THERMAL_BIT = 2;
    localparam int STAT_UNDERVOLT_BIT = 3;
    localparam int STAT_DRIVER_ON_BIT = 4;
    localparam int STAT_FAULT_BIT = 5;
    localparam int STAT_W = 6;

    // Supply protection states
    typedef enum logic [1:0] {
        SUPPLY_NORMAL,
        SUPPLY_PROTECTED,
        SUPPLY_RECOVERING
    } supply_state_t;
endpackage

// ==== rtl/dominant_timeout.sv ====
// Dominant-timeout supervisor: times a low level on one line.
// Assumes the line is synchronous to clk_i; count given by the parent.
`timescale 1ns/10ps
module dominant_timeout
    import can_phy_pkg::*;
#(
    parameter logic [TIMER_W-1:0] LIMIT = 16'h0010
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic line_i,
    output logic expired_o
);
    logic [TIMER_W-1:0] count;
    logic [TIMER_W-1:0] next_count;
    logic line_q;
    logic next_line_q;
    logic next_expired;

    // Count while low; any high clears both counter and expiry
    always_comb begin
        next_line_q = line_i;
        next_count = count;
        next_expired = expired_o;
        if (!enable_i || line_i) begin
            next_count = '0; // R24
            next_expired = 1'b0;
        end else if (line_q && !line_i) begin
            next_count = '0; // R24
        end else if (!expired_o) begin
            if (count == LIMIT - 16'h0001) begin
                next_expired = 1'b1;
            end else begin
                next_count = count + 16'h0001;
            end
        end
    end

    // Line idles high, so a reset never reads as a falling edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            line_q <= 1'b1;
            expired_o <= 1'b0;
        end else begin
            count <= next_count;
            line_q <= next_line_q;
            expired_o <= next_expired;
        end
    end
endmodule

// ==== rtl/wb_regs.sv ====
// Classic Wishbone slave holding the control and status words.
// Assumes single-cycle classic cycles; ack follows one cycle after stb.
`timescale 1ns/10ps
module wb_regs
    import can_phy_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [STAT_W-1:0] status_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic [2:0] control_o
);
    logic [31:0] next_dat;
    logic next_ack;
    logic [2:0] next_control;

    // Answer every address; unmapped ones read zero and ignore writes
    always_comb begin
        next_ack = 1'b0;
        next_dat = dat_o;
        next_control = control_o;
        if (cyc_i && stb_i && !ack_o) begin
            next_ack = 1'b1;
            if (!we_i) begin
                case (adr_i)
                    ADDR_CONTROL: next_dat = {29'h0, control_o};
                    ADDR_STATUS: next_dat = {26'h0, status_i};
                    default: next_dat = 32'h0;
                endcase
            end
        end
        // Writes land at the edge where the master sees ack, while it still holds the request
        if (cyc_i && stb_i && we_i && ack_o && adr_i == ADDR_CONTROL && sel_i[0]) begin
            next_control = dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
            ack_o <= 1'b0;
            control_o <= CTRL_RESET;
        end else begin
            dat_o <= next_dat;
            ack_o <= next_ack;
            control_o <= next_control;
        end
    end
endmodule

// ==== tb/can_phy_ctrl_chk.sv ====
// Checker for the transceiver control block, looking at its ports only.
// Assumes it is bound to can_phy_ctrl; helper counters time dominant runs.
`timescale 1ns/10ps
module can_phy_ctrl_chk
    import can_phy_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic txd_i,
    input wire logic txd_float_i,
    input wire logic silent_i,
    input wire logic silent_float_i,
    input wire logic rxd_o,
    input wire logic rxd_oe_o,
    input wire logic bus_dominant_i,
    input wire logic bus_drive_dominant_o,
    input wire logic over_temp_i,
    input wire logic fault_o,
    input wire logic fault_oe_o,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o
);
    // Margin of a few cycles covers the output register stage
    localparam int TX_LIM = TX_TIMEOUT_CYCLES + 3;
    localparam int RX_LIM = RX_TIMEOUT_CYCLES + 3;
    logic [15:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
    logic rx_sup, next_rx_sup;
    // Saturating run counters, so a stuck line never wraps them
    always_comb begin
        // Silent mode stops the transmit timer, so the run restarts with it
        next_tx_cnt = (txd_i | txd_float_i | (silent_i & ~silent_float_i)) ? 16'h0 : tx_cnt + {15'h0, ~&tx_cnt};
        next_rx_cnt = bus_dominant_i ? rx_cnt + {15'h0, ~&rx_cnt} : 16'h0;
        next_rx_sup = rx_sup;
        if (cyc_i && stb_i && we_i && ack_o && adr_i == ADDR_CONTROL && sel_i[0]) begin
            next_rx_sup = dat_i[CTRL_RX_SUPERVISE_BIT];
        end
    end
    always_ff @(posedge clk_i) begin
        tx_cnt <= rst_i ? 16'h0 : next_tx_cnt;
        rx_cnt <= rst_i ? 16'h0 : next_rx_cnt;
        rx_sup <= rst_i ? 1'b0 : next_rx_sup;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_silent_quiet:
    assert property ((silent_i & ~silent_float_i) |=> !bus_drive_dominant_o)
        else $error("driver on in silent mode");
    chk_drive_cause:
    assert property (bus_drive_dominant_o |-> $past(~txd_i & ~txd_float_i & ~over_temp_i))
        else $error("driver on without a dominant transmit input");
    chk_tx_release:
    assert property (tx_cnt > TX_LIM |-> !bus_drive_dominant_o)
        else $error("driver still on after transmit timeout");
    chk_rx_release:
    assert property (rx_sup && rxd_oe_o && rx_cnt > RX_LIM |-> rxd_o)
        else $error("receive output still low after receive timeout");
    chk_rx_mirror:
    assert property (rxd_oe_o && !$past(bus_dominant_i) |-> rxd_o)
        else $error("receive output low on a recessive bus");
    chk_thermal_off:
    assert property (over_temp_i |=> !bus_drive_dominant_o)
        else $error("driver on during over-temperature");
    chk_fault_raise:
    assert property (over_temp_i || tx_cnt > TX_LIM |=> !fault_oe_o)
        else $error("fault pin not released during a fault");
    chk_fault_open:
    assert property (fault_oe_o |-> !fault_o)
        else $error("fault pin driven high");
endmodule

// ==== tb/can_ctrl_model.sv ====
// Model of the CAN protocol controller on the transmit side.
// Assumes the bench commands runs; bit time is given in clock cycles.
`timescale 1ns/10ps
module can_ctrl_model #(
    parameter int BIT_CYCLES = 1000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [3:0] nbits_i,
    input wire logic hold_low_i,
    input wire logic silent_req_i,
    output logic txd_o,
    output logic silent_o,
    output logic busy_o
);
    logic [15:0] cnt, next_cnt;
    logic [3:0] bits, next_bits;
    // A run of dominant bits, then one recessive bit before idle
    always_comb begin
        next_cnt = cnt;
        next_bits = bits;
        if (start_i && !busy_o) begin
            next_bits = nbits_i + 4'h1;
            next_cnt = 16'(BIT_CYCLES);
        end else if (bits != 4'h0) begin
            next_cnt = cnt - 16'h1;
            if (cnt == 16'h1) begin
                next_bits = bits - 4'h1;
                next_cnt = 16'(BIT_CYCLES);
            end
        end
    end
    always_ff @(posedge clk_i) begin
        cnt <= rst_i ? 16'h0 : next_cnt;
        bits <= rst_i ? 4'h0 : next_bits;
    end
    // Eleven bits at this bit time end before the shortest timeout
    assign txd_o = ~((bits > 4'h1) | hold_low_i);
    assign silent_o = silent_req_i;
    assign busy_o = bits != 4'h0;
endmodule

// ==== tb/can_phy_ctrl_bench.sv ====
// Bench for the transceiver control block: pins, supplies, registers.
// Assumes the package is compiled first; the bus level is resolved here.
`timescale 1ns/10ps
module can_phy_ctrl_bench import can_phy_pkg::*;;
    logic clk_i = 1'b0, rst_i = 1'b1, txd_float_i = 1'b0, silent_float_i = 1'b0;
    logic over_temp_i = 1'b0, main_supply_good_i = 1'b1, out_supply_good_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ext_dom = 1'b0;
    logic hold_low = 1'b0, silent_req = 1'b0, start = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, rdata, dat_o;
    logic txd_i, silent_i, bus_dominant_i, rxd_o, rxd_oe_o, bus_drive_dominant_o;
    logic bus_bias_o, fault_o, fault_oe_o, ack_o, busy;
    int err_total = 0, num_checks = 0;
    // Wired bus: dominant if this driver or another node pulls it
    assign bus_dominant_i = bus_drive_dominant_o | ext_dom;
    can_phy_ctrl can_phy_ctrl_i (.clk_i, .rst_i, .txd_i, .txd_float_i, .silent_i, .silent_float_i, .rxd_o,
        .rxd_oe_o, .bus_dominant_i, .bus_drive_dominant_o, .bus_bias_o, .over_temp_i, .main_supply_good_i,
        .out_supply_good_i, .fault_o, .fault_oe_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o);
    can_ctrl_model #(.BIT_CYCLES(1000)) can_ctrl_model_i (.clk_i, .rst_i, .start_i(start), .nbits_i(4'hb),
        .hold_low_i(hold_low), .silent_req_i(silent_req), .txd_o(txd_i), .silent_o(silent_i), .busy_o(busy));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One classic cycle; a lost ack ends the run
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        for (int i = 0; i < 20 && ack_o !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        if (ack_o !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        rdata = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        step(2);
    endtask
    initial begin
        step(12);
        check("reset outputs", {bus_drive_dominant_o, bus_bias_o, rxd_oe_o, fault_oe_o, rxd_o}, 5'h01);
        rst_i <= 1'b0;
        step(1);
        wb(0, ADDR_CONTROL, 0);
        check("control reset", rdata, 32'h0);
        wb(1, 4'h8, 32'h7);
        wb(0, 4'h8, 0);
        check("unmapped read", rdata, 32'h0);
        wb(0, ADDR_STATUS, 0);
        check("status in recovery", rdata, 32'h28);
        step(RECOVERY_CYCLES - 60);
        check("fault before recovery", fault_oe_o, 1'b0);
        step(80);
        check("recovered", {bus_bias_o, rxd_oe_o, fault_oe_o}, 3'h7);
        wb(1, ADDR_CONTROL, 32'h2);
        wb(0, ADDR_CONTROL, 0);
        check("control readback", rdata, 32'h2);
        hold_low <= 1'b1;
        step(3);
        check("normal dominant", {bus_drive_dominant_o, rxd_o}, 2'b10);
        txd_float_i <= 1'b1;
        step(3);
        check("floating transmit", bus_drive_dominant_o, 1'b0);
        txd_float_i <= 1'b0;
        silent_req <= 1'b1;
        silent_float_i <= 1'b1;
        step(3);
        check("floating silent", bus_drive_dominant_o, 1'b1);
        silent_float_i <= 1'b0;
        ext_dom <= 1'b1;
        step(3);
        check("silent mode", {bus_drive_dominant_o, rxd_o}, 2'b00);
        ext_dom <= 1'b0;
        silent_req <= 1'b0;
        // Software silent bit alone must also keep the driver off
        wb(1, ADDR_CONTROL, 32'h3);
        step(3);
        check("software silent", bus_drive_dominant_o, 1'b0);
        wb(1, ADDR_CONTROL, 32'h2);
        hold_low <= 1'b0;
        step(3);
        // Two full-length worst-case runs: the timer restarts on each
        for (int k = 0; k < 2; k++) begin
            start <= 1'b1;
            step(1);
            start <= 1'b0;
            step(10990);
            check("long run", {bus_drive_dominant_o, fault_oe_o}, 2'b11);
            step(1100);
        end
        hold_low <= 1'b1;
        step(TX_TIMEOUT_CYCLES - 10);
        check("before transmit timeout", bus_drive_dominant_o, 1'b1);
        step(20);
        check("transmit timeout", {bus_drive_dominant_o, bus_bias_o, fault_oe_o}, 3'b010);
        ext_dom <= 1'b1;
        step(3);
        check("receive during timeout", rxd_o, 1'b0);
        ext_dom <= 1'b0;
        wb(0, ADDR_STATUS, 0);
        check("status transmit timeout", {rdata[5], rdata[0]}, 2'b11);
        hold_low <= 1'b0;
        step(3);
        check("timeout cleared", fault_oe_o, 1'b1);
        hold_low <= 1'b1;
        step(3);
        check("driver back", bus_drive_dominant_o, 1'b1);
        hold_low <= 1'b0;
        ext_dom <= 1'b1;
        step(RX_TIMEOUT_CYCLES - 10);
        check("before receive timeout", rxd_o, 1'b0);
        step(20);
        check("receive timeout", {rxd_o, fault_oe_o}, 2'b10);
        wb(0, ADDR_STATUS, 0);
        check("status receive timeout", rdata, 32'h22);
        hold_low <= 1'b1;
        step(3);
        check("bus kept recessive", {bus_drive_dominant_o, bus_bias_o}, 2'b01);
        hold_low <= 1'b0;
        ext_dom <= 1'b0;
        step(3);
        ext_dom <= 1'b1;
        step(3);
        check("mirroring again", {rxd_o, fault_oe_o}, 2'b01);
        ext_dom <= 1'b0;
        over_temp_i <= 1'b1;
        hold_low <= 1'b1;
        step(3);
        ext_dom <= 1'b1;
        step(3);
        check("thermal", {bus_drive_dominant_o, bus_bias_o, rxd_o, fault_oe_o}, 4'b0100);
        wb(0, ADDR_STATUS, 0);
        check("status thermal", rdata, 32'h24);
        over_temp_i <= 1'b0;
        ext_dom <= 1'b0;
        step(3);
        check("thermal cleared", {bus_drive_dominant_o, fault_oe_o}, 2'b11);
        hold_low <= 1'b0;
        main_supply_good_i <= 1'b0;
        step(3);
        check("main bad single", {bus_bias_o, rxd_oe_o, fault_oe_o}, 3'b000);
        main_supply_good_i <= 1'b1;
        step(RECOVERY_CYCLES - 20);
        check("still recovering", fault_oe_o, 1'b0);
        step(40);
        wb(1, ADDR_CONTROL, 32'h6);
        main_supply_good_i <= 1'b0;
        step(3);
        check("main bad dual", {bus_bias_o, rxd_oe_o, rxd_o, fault_oe_o}, 4'b0110);
        main_supply_good_i <= 1'b1;
        out_supply_good_i <= 1'b0;
        step(3);
        check("output bad dual", {bus_bias_o, rxd_oe_o, fault_oe_o}, 3'b100);
        out_supply_good_i <= 1'b1;
        step(RECOVERY_CYCLES + 20);
        check("dual recovered", fault_oe_o, 1'b1);
        end_of_test();
    end
endmodule
bind can_phy_ctrl can_phy_ctrl_chk can_phy_ctrl_chk_i (.clk_i, .rst_i, .txd_i, .txd_float_i, .silent_i,
    .silent_float_i, .rxd_o, .rxd_oe_o, .bus_dominant_i, .bus_drive_dominant_o, .over_temp_i, .fault_o,
    .fault_oe_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o);
